// >>> logic/iseea_cfg.svh
`ifndef ISEEA_CFG_SVH
`define ISEEA_CFG_SVH

// Memory shape
`define ISEEA_ADDR_W      11
`define ISEEA_PAGE_W      4

// Control byte field positions
`define ISEEA_CODE_HI     7
`define ISEEA_CODE_LO     4
`define ISEEA_BLK_HI      3
`define ISEEA_BLK_LO      1
`define ISEEA_RW_BIT      0
`define ISEEA_BLK_SHIFT   8

// Bit counter value of the last bit of a byte
`define ISEEA_BIT_LAST    3'h7

// Reset values
`define ISEEA_OE_N_RST    1'b1
`define ISEEA_STATE_RST   4'b0000

// Programming cycle time
`define ISEEA_CLK_MHZ     100
`define ISEEA_TWR_US      5000
`define ISEEA_TWR_CYCLES  (`ISEEA_TWR_US * `ISEEA_CLK_MHZ)

`endif

// >>> logic/iseea_pkg.sv
package iseea_pkg;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_CTRL      = 4'b0001,
      ST_CTRL_ACK  = 4'b0010,
      ST_ADDR      = 4'b0011,
      ST_ADDR_ACK  = 4'b0100,
      ST_WDATA     = 4'b0101,
      ST_WDATA_ACK = 4'b0110,
      ST_RDATA     = 4'b0111,
      ST_RACK      = 4'b1000
   } iseea_state_type;

   typedef struct packed {
      logic sda_o;
      logic sda_oe_n;
   } iseea_drive_type;

endpackage : iseea_pkg

// >>> logic/iseea_top.sv
`timescale 1ns/10ps
`include "iseea_cfg.svh"
// Behaviour
// [R1] Idle bus: both lines high; device never pulls SDA low when idle.
// [R2] Master frames: START is SDA fall, STOP is SDA rise, SCL high.
// [R3] SDA stable while SCL high; changes only while SCL low; one bit per pulse.
// [R4] First byte after START: seven-bit address, direction bit last, 0 write.
// [R5] Ninth pulse per byte; receiver acknowledges by holding SDA low.
// [R6] Busy receiver or finishing master leaves SDA high on ninth pulse.
// [R7] Addressed receiver acknowledges each byte; master ends with STOP.
// [R8] Bytes move MSB first, eight bits plus acknowledge; master sets count.
// [R9] Upper four control bits must match device code, else no response.
// [R10] Next three control bits select 256-byte block, top address bits.
// [R11] On matching control byte, acknowledge, then read or write per direction.
// [R12] No acknowledge at all while a programming cycle runs.
// [R13] Byte write: control, word address, data, each acknowledged, then STOP.
// [R14] Page write up to sixteen bytes; pointer advances after each byte.
// [R15] Reads start like writes with direction bit one.
// [R16] Current-address read returns byte after last access; master nacks, stops.
// [R17] Random read: dummy write of address, then current-address read.
// [R18] Sequential read continues while master acknowledges; nack plus STOP ends.
// [R19] STOP after a write starts programming; nack until it completes.
module iseea_top
   import iseea_pkg::*;
#(
   parameter int         ADDR_W     = `ISEEA_ADDR_W,
   parameter int         PAGE_W     = `ISEEA_PAGE_W,
   parameter int         TWR_CYCLES = `ISEEA_TWR_CYCLES,
   // Arbitrary value
   parameter logic [3:0] DEV_CODE   = 4'h5
)(
   // System
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   // Two-wire link
   input  wire logic                       scl,
   input  wire logic                       sda_in,
   output iseea_pkg::iseea_drive_type      sda_drv,
   // Status
   output logic                            prog_busy
);
   import iseea_pkg::*;

   localparam int PAGE  = 2 ** PAGE_W;
   localparam int DEPTH = 2 ** ADDR_W;
   localparam int CNT_W = $clog2(TWR_CYCLES + 1);

   function automatic logic ctrl_match(input logic [7:0] b, input logic [3:0] code);
      ctrl_match = (b[`ISEEA_CODE_HI:`ISEEA_CODE_LO] == code);
   endfunction : ctrl_match

   // Frame markers, clocked by SDA edges
   logic                       start_tog;
   logic                       stop_tog;
   // Link domain
   logic                       start_seen;
   logic                       start_pend;
   iseea_state_type            state;
   logic [2:0]                 bitcnt;
   logic [7:0]                 shift;
   logic [7:0]                 next_shift;
   logic                       ack_ok;
   logic [2:0]                 blk;
   logic [ADDR_W-1:0]          ptr;
   logic [7:0]                 rd_byte;
   logic [7:0]                 mem [DEPTH];
   logic [7:0]                 pbuf [PAGE];
   logic [PAGE-1:0]            pvalid;
   logic [ADDR_W-PAGE_W-1:0]   ppage;
   logic                       wr_dirty;
   logic                       done_s1;
   logic                       done_s2;
   logic                       done_seen;
   logic                       commit;
   logic                       sda_oe_n;
   logic                       block_select_bit2;
   logic                       block_select_bit1;
   logic                       block_select_bit0;
   // System domain
   logic                       stop_s1;
   logic                       stop_s2;
   logic                       stop_s3;
   logic                       stop_pulse;
   logic                       dirty_s1;
   logic                       dirty_s2;
   logic                       busy;
   logic                       armed;
   logic [CNT_W-1:0]           cnt;
   logic                       done_tog;

   // START and STOP are only visible as SDA edges with SCL high
   always_ff @(negedge sda_in or posedge sys_rst) begin
      if (sys_rst) begin
         start_tog <= 1'b0;
      end else if (scl) begin
         start_tog <= ~start_tog; // [R2]
      end
   end

   always_ff @(posedge sda_in or posedge sys_rst) begin
      if (sys_rst) begin
         stop_tog <= 1'b0;
      end else if (scl) begin
         stop_tog <= ~stop_tog; // [R2]
      end
   end

   // Toggle settles half a clock before the next SCL rise; SCL stands still between frames
   assign start_pend        = (start_tog != start_seen);
   assign next_shift        = {shift[6:0], sda_in}; // [R8]
   assign block_select_bit2 = next_shift[`ISEEA_BLK_HI];
   assign block_select_bit1 = next_shift[`ISEEA_BLK_HI-1];
   assign block_select_bit0 = next_shift[`ISEEA_BLK_LO];
   assign commit            = (done_s2 != done_seen);

   // Protocol engine, samples SDA on SCL rise
   always_ff @(posedge scl or posedge sys_rst) begin
      if (sys_rst) begin
         state      <= iseea_state_type'(`ISEEA_STATE_RST);
         bitcnt     <= 3'h0;
         shift      <= 8'h00;
         ack_ok     <= 1'b0;
         start_seen <= 1'b0;
      end else if (start_pend) begin
         start_seen <= start_tog;
         state      <= ST_CTRL;
         bitcnt     <= 3'h1;
         shift      <= {7'h00, sda_in};
         ack_ok     <= 1'b0;
      end else begin
         case (state)
            ST_CTRL: begin
               shift  <= next_shift;
               bitcnt <= bitcnt + 3'h1; // [R3]
               if (bitcnt == `ISEEA_BIT_LAST) begin
                  state  <= ST_CTRL_ACK;
                  ack_ok <= ctrl_match(next_shift, DEV_CODE) && !wr_dirty; // [R4] [R9] [R11] [R12] [R19]
               end
            end
            ST_ADDR: begin
               shift  <= next_shift;
               bitcnt <= bitcnt + 3'h1;
               if (bitcnt == `ISEEA_BIT_LAST) begin
                  state  <= ST_ADDR_ACK;
                  ack_ok <= 1'b1; // [R7] [R13]
               end
            end
            ST_WDATA: begin
               shift  <= next_shift;
               bitcnt <= bitcnt + 3'h1;
               if (bitcnt == `ISEEA_BIT_LAST) begin
                  state  <= ST_WDATA_ACK;
                  ack_ok <= 1'b1; // [R7] [R13]
               end
            end
            ST_CTRL_ACK: begin
               bitcnt <= 3'h0;
               if (!ack_ok) begin
                  state <= ST_IDLE;
               end else if (shift[`ISEEA_RW_BIT]) begin
                  state <= ST_RDATA; // [R15] [R16]
               end else begin
                  state <= ST_ADDR;
               end
            end
            ST_ADDR_ACK, ST_WDATA_ACK: begin
               bitcnt <= 3'h0;
               state  <= ST_WDATA;
            end
            ST_RDATA: begin
               bitcnt <= bitcnt + 3'h1;
               if (bitcnt == `ISEEA_BIT_LAST) begin
                  state <= ST_RACK;
               end
            end
            ST_RACK: begin
               bitcnt <= 3'h0;
               if (sda_in) begin
                  state <= ST_IDLE; // [R6] [R18]
               end else begin
                  state <= ST_RDATA; // [R18]
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Address pointer, page buffer and read byte
   always_ff @(posedge scl or posedge sys_rst) begin
      if (sys_rst) begin
         blk       <= 3'h0;
         ptr       <= '0;
         rd_byte   <= 8'h00;
         pvalid    <= '0;
         ppage     <= '0;
         wr_dirty  <= 1'b0;
         done_seen <= 1'b0;
         for (int i = 0; i < PAGE; i++) begin
            pbuf[i] <= 8'h00;
         end
      end else begin
         if (commit) begin
            done_seen <= done_s2;
            wr_dirty  <= 1'b0;
            pvalid    <= '0;
         end
         if (!start_pend) begin
            if (state == ST_CTRL && bitcnt == `ISEEA_BIT_LAST) begin
               blk <= {block_select_bit2, block_select_bit1, block_select_bit0};
            end
            if (state == ST_ADDR && bitcnt == `ISEEA_BIT_LAST) begin
               ptr    <= ADDR_W'({blk, next_shift}); // [R10] [R17]
               ppage  <= (ADDR_W-PAGE_W)'({blk, next_shift} >> PAGE_W);
               pvalid <= '0;
            end
            if (state == ST_WDATA && bitcnt == `ISEEA_BIT_LAST) begin
               // Past sixteen bytes the pointer wraps and overwrites within the page
               pbuf[ptr[PAGE_W-1:0]]   <= next_shift;
               pvalid[ptr[PAGE_W-1:0]] <= 1'b1;
               wr_dirty                <= 1'b1;
               ptr[PAGE_W-1:0]         <= ptr[PAGE_W-1:0] + PAGE_W'(1); // [R14]
            end
            if ((state == ST_CTRL_ACK && ack_ok && shift[`ISEEA_RW_BIT]) || (state == ST_RACK && !sda_in)) begin
               rd_byte <= mem[ptr]; // [R16] [R18]
               ptr     <= ptr + ADDR_W'(1);
            end
         end
      end
   end

   // Array update once the programming time has elapsed
   always_ff @(posedge scl) begin
      if (commit) begin
         for (int i = 0; i < PAGE; i++) begin
            if (pvalid[i]) begin
               mem[{ppage, PAGE_W'(i)}] <= pbuf[i];
            end
         end
      end
   end

   // Done toggle from the system domain
   always_ff @(posedge scl or posedge sys_rst) begin
      if (sys_rst) begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
      end else begin
         done_s1 <= done_tog;
         done_s2 <= done_s1;
      end
   end

   // SDA driven on SCL fall so it is settled through the high phase
   always_ff @(negedge scl or posedge sys_rst) begin
      if (sys_rst) begin
         sda_oe_n <= `ISEEA_OE_N_RST;
      end else if (start_pend) begin
         sda_oe_n <= 1'b1; // [R1]
      end else begin
         case (state)
            ST_CTRL_ACK, ST_ADDR_ACK, ST_WDATA_ACK: begin
               sda_oe_n <= ~ack_ok; // [R3] [R5] [R6]
            end
            ST_RDATA: begin
               sda_oe_n <= rd_byte[3'h7 - bitcnt]; // [R3] [R8]
            end
            default: begin
               sda_oe_n <= 1'b1; // [R1]
            end
         endcase
      end
   end

   assign sda_drv = '{sda_o: 1'b0, sda_oe_n: sda_oe_n};
   // System domain: STOP and dirty flag are levels once SCL stops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stop_s1  <= 1'b0;
         stop_s2  <= 1'b0;
         stop_s3  <= 1'b0;
         dirty_s1 <= 1'b0;
         dirty_s2 <= 1'b0;
      end else begin
         stop_s1  <= stop_tog;
         stop_s2  <= stop_s1;
         stop_s3  <= stop_s2;
         dirty_s1 <= wr_dirty;
         dirty_s2 <= dirty_s1;
      end
   end

   assign stop_pulse = stop_s2 ^ stop_s3;
   // Programming timer; armed blocks a second run on a stale dirty flag
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy     <= 1'b0;
         cnt      <= '0;
         done_tog <= 1'b0;
         armed    <= 1'b1;
      end else if (busy) begin
         if (cnt == CNT_W'(TWR_CYCLES - 1)) begin
            busy     <= 1'b0;
            done_tog <= ~done_tog; // [R19]
         end else begin
            cnt <= cnt + CNT_W'(1);
         end
      end else if (stop_pulse && dirty_s2 && armed) begin
         busy  <= 1'b1; // [R19]
         cnt   <= '0;
         armed <= 1'b0;
      end else if (!dirty_s2) begin
         armed <= 1'b1;
      end
   end

   assign prog_busy = busy;

   sequence s_ctrl_last;
      state == ST_CTRL && bitcnt == 3'h7 && !start_pend;
   endsequence
   sequence s_rack_bit;
      state == ST_RACK && !start_pend;
   endsequence
   a_ctrl_ack_match: assert property (@(posedge scl) disable iff (sys_rst) // [R11]
      s_ctrl_last ##0 (ctrl_match(next_shift, DEV_CODE) && !wr_dirty) |=> (state == ST_CTRL_ACK && ack_ok))
      else $error("Matching control byte not acknowledged");
   a_code_mismatch: assert property (@(posedge scl) disable iff (sys_rst) // [R9]
      s_ctrl_last ##0 !ctrl_match(next_shift, DEV_CODE) |=> !ack_ok)
      else $error("Foreign control byte acknowledged");
   a_busy_nack: assert property (@(posedge scl) disable iff (sys_rst) // [R12]
      s_ctrl_last ##0 wr_dirty |=> !ack_ok)
      else $error("Control byte acknowledged during programming");
   a_ack_drive: assert property (@(posedge scl) disable iff (sys_rst) // [R5]
      ((state == ST_CTRL_ACK || state == ST_ADDR_ACK || state == ST_WDATA_ACK) && ack_ok && !start_pend)
      |-> !sda_oe_n)
      else $error("Acknowledge not driven low");
   a_idle_release: assert property (@(posedge scl) disable iff (sys_rst) // [R1]
      (state == ST_IDLE) |-> sda_oe_n)
      else $error("SDA pulled low while idle");
   a_read_msb: assert property (@(posedge scl) disable iff (sys_rst) // [R8]
      (state == ST_RDATA && !start_pend) |-> (sda_oe_n == rd_byte[3'h7 - bitcnt]))
      else $error("Read bit order wrong");
   a_master_nack: assert property (@(posedge scl) disable iff (sys_rst) // [R6]
      s_rack_bit ##0 sda_in |=> state == ST_IDLE)
      else $error("Read not ended on master nack");
   a_seq_next: assert property (@(posedge scl) disable iff (sys_rst) // [R18]
      s_rack_bit ##0 !sda_in |=> (state == ST_RDATA && ptr == ADDR_W'($past(ptr) + 1'b1)))
      else $error("Sequential read did not advance");
   a_page_incr: assert property (@(posedge scl) disable iff (sys_rst) // [R14]
      (state == ST_WDATA && bitcnt == 3'h7 && !start_pend)
      |=> (ptr[PAGE_W-1:0] == PAGE_W'($past(ptr[PAGE_W-1:0]) + 1'b1)) && wr_dirty)
      else $error("Write pointer did not advance");
   a_block_addr: assert property (@(posedge scl) disable iff (sys_rst) // [R10]
      (state == ST_ADDR && bitcnt == 3'h7 && !start_pend) |=> (ptr[ADDR_W-1:`ISEEA_BLK_SHIFT] == $past(blk)))
      else $error("Block bits not placed on top of address");
   a_prog_start: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
      (stop_pulse && dirty_s2 && armed && !busy) |=> busy [*2])
      else $error("Programming did not start after write STOP");
   a_prog_end: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
      $fell(busy) |-> (done_tog != $past(done_tog)) && (cnt == CNT_W'(TWR_CYCLES - 1)))
      else $error("Programming ended early or without done");

endmodule : iseea_top

// >>> sim/iseea_master.sv
`timescale 1ns/10ps
module iseea_master (
   // Link
   output logic      scl,
   output logic      sda_oe_n,
   input  wire logic sda
);
   // Extra low time per bit, to play a slow master
   int slow;

   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
      slow = 0;
   end

   // The #1 keeps SDA edges clear of the SCL fall, so no false frame is seen
   task automatic start();
      #1 sda_oe_n = 1'b1;
      #3 scl = 1'b1;
      #3 sda_oe_n = 1'b0;
      #3 scl = 1'b0;
   endtask : start

   task automatic stop();
      #1 sda_oe_n = 1'b0;
      #3 scl = 1'b1;
      #3 sda_oe_n = 1'b1;
      #3;
   endtask : stop

   // SDA set while SCL low, sampled mid-high, one bit per pulse
   task automatic bit_io(input logic b, output logic s);
      #1 sda_oe_n = b;
      #(2 + slow) scl = 1'b1;
      #1 s = sda;
      #2 scl = 1'b0;
   endtask : bit_io

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, ack);
   endtask : wbyte

   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(nack, s);
   endtask : rbyte
endmodule : iseea_master

// >>> sim/iseea_top_tb.sv
`timescale 1ns/10ps
module iseea_top_tb;
   import iseea_pkg::*;
   localparam int         TWR = 20;
   // Arbitrary device code
   localparam logic [3:0] DEV = 4'h6;
   logic            clk;
   logic            sys_rst;
   logic            sda_in;
   logic            ack;
   logic            busy;
   wire logic       scl;
   wire logic       m_oe_n;
   iseea_drive_type drv;
   int              seed;
   int              bad_count;
   int              checks;
   logic [7:0]      mem [0:2047];
   logic [10:0]     base;

   iseea_top #(.TWR_CYCLES(TWR), .DEV_CODE(DEV)) dut (
      .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_in), .sda_drv(drv), .prog_busy(busy));
   iseea_master m (.scl(scl), .sda_oe_n(m_oe_n), .sda(sda_in));

   // Open-drain wire with pull-up
   assign sda_in = m_oe_n & (drv.sda_oe_n | drv.sda_o);

   always #5 clk = ~clk;

   function automatic logic [7:0] ctrl(input logic [2:0] blk, input logic rw);
      return {DEV, blk, rw};
   endfunction : ctrl

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   always @(drv.sda_oe_n) begin
      if (scl === 1'b1 && sys_rst === 1'b0) chk("oe_n moved with scl high", 8'(scl), 8'h00);
   end

   // Programming must hold off every control byte until it is done
   task automatic poll();
      logic k;
      m.start();
      m.wbyte(ctrl(3'h0, 1'b0), k);
      m.stop();
      chk("busy nack", 8'(k), 8'h01);
      for (int i = 0; i < 100 && k !== 1'b0; i++) begin
         #40;
         m.start();
         m.wbyte(ctrl(3'h0, 1'b0), k);
         m.stop();
      end
      chk("ready ack", 8'(k), 8'h00);
      chk("idle oe_n", 8'(drv.sda_oe_n), 8'h01);
   endtask : poll

   task automatic write_bytes(input logic [10:0] a, input int cnt);
      logic       k;
      logic [7:0] v;
      m.start();
      m.wbyte(ctrl(a[10:8], 1'b0), k);
      chk("ctrl ack", 8'(k), 8'h00);
      m.wbyte(a[7:0], k);
      chk("addr ack", 8'(k), 8'h00);
      for (int i = 0; i < cnt; i++) begin
         v = 8'($random(seed));
         mem[{a[10:4], 4'(a[3:0] + 4'(i))}] = v;
         m.wbyte(v, k);
         chk("data ack", 8'(k), 8'h00);
      end
      m.stop();
      repeat (8) @(posedge clk);
      #1 chk("prog busy", 8'(busy), 8'h01);
      poll();
   endtask : write_bytes

   task automatic read_bytes(input logic [10:0] a, input int cnt, input logic cur);
      logic       k;
      logic [7:0] v;
      if (!cur) begin
         m.start();
         m.wbyte(ctrl(a[10:8], 1'b0), k);
         m.wbyte(a[7:0], k);
         chk("dummy ack", 8'(k), 8'h00);
      end
      m.start();
      m.wbyte(ctrl(a[10:8], 1'b1), k);
      chk("read ctrl ack", 8'(k), 8'h00);
      for (int i = 0; i < cnt; i++) begin
         m.rbyte(i == cnt - 1, v);
         chk("read data", v, mem[a + 11'(i)]);
      end
      m.stop();
   endtask : read_bytes

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   initial begin
      #100000;
      chk("watchdog", 8'h00, 8'h01);
      test_done();
   end

   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      seed = 49339;
      bad_count = 0;
      checks = 0;
      repeat (16) @(posedge clk);
      #1 sys_rst = 1'b0;
      @(posedge clk);
      #1 chk("reset oe_n", 8'(drv.sda_oe_n), 8'h01);
      chk("reset busy", 8'(busy), 8'h00);
      $display("test reset done");
      m.start();
      m.wbyte({~DEV, 3'h0, 1'b0}, ack);
      m.stop();
      chk("foreign code nack", 8'(ack), 8'h01);
      $display("test foreign code done");
      base = 11'($random(seed)) & 11'h7F0;
      m.slow = 7;
      write_bytes(base, 16);
      m.slow = 0;
      $display("test page write done");
      read_bytes(base + 11'd5, 1, 1'b0);
      read_bytes(base + 11'd6, 1, 1'b1);
      $display("test random and current read done");
      read_bytes(base, 16, 1'b0);
      $display("test sequential read done");
      base = base ^ 11'h400;
      // Seventeen bytes from offset 9 wrap and overwrite offset 9
      write_bytes(base + 11'd9, 17);
      read_bytes(base, 16, 1'b0);
      $display("test page wrap done");
      base = 11'($random(seed));
      write_bytes(base, 1);
      read_bytes(base, 1, 1'b0);
      $display("test byte write done");
      test_done();
   end
endmodule : iseea_top_tb
